//--- verilog/abt_pkg.sv
package abt_pkg;

    // ----------------------------------------
    // Instruction codes
    // ----------------------------------------
    localparam logic [7:0] INS_FETCH = 8'h12;
    localparam logic [7:0] INS_TERM_RSP = 8'h14;
    localparam logic [7:0] INS_ENVELOPE = 8'hC2;

    // ----------------------------------------
    // Status words
    // ----------------------------------------
    localparam logic [15:0] SW_OK = 16'h9000;
    localparam logic [7:0] SW1_OK = 8'h90;
    localparam logic [7:0] SW2_OK = 8'h00;
    localparam logic [7:0] SW1_PENDING = 8'h91;
    localparam logic [15:0] SW_TK_BUSY = 16'h9300;
    localparam logic [7:0] SW1_MORE = 8'h61;
    localparam logic [7:0] SW1_WARN_A = 8'h62;
    localparam logic [7:0] SW1_WARN_B = 8'h63;
    localparam logic [3:0] SW1_APP_HI = 4'h9;

    // ----------------------------------------
    // Sizes and header layout
    // ----------------------------------------
    localparam int HDR_BYTES = 4;
    localparam int HDR_INS = 1;
    localparam int BLK_MAX = 254;
    localparam int RSP_MAX = 256;

    typedef enum logic [2:0] {
        ABT_IDLE,
        ABT_CMD,
        ABT_EXEC,
        ABT_DATA,
        ABT_SW1,
        ABT_SW2
    } abt_state_e;

endpackage

//--- verilog/abt_sw_filter.sv
`timescale 1ns/1ps
module abt_sw_filter (
    input wire logic [15:0] sw,
    input wire logic pending,
    input wire logic tk_busy,
    input wire logic is_envelope,
    output logic [15:0] sw_out,
    output logic data_ok
);
    logic [15:0] s;
    always_comb begin
        s = sw;
        if (is_envelope && tk_busy) begin
            s = abt_pkg::SW_TK_BUSY;
        end else if (sw == abt_pkg::SW_OK && pending) begin
            s = {abt_pkg::SW1_PENDING, 8'h00};
        end
        sw_out = s;
        // Data only travels with these status classes
        data_ok = (s[15:8] == abt_pkg::SW1_MORE) || (s[15:8] == abt_pkg::SW1_WARN_A) ||
                  (s[15:8] == abt_pkg::SW1_WARN_B) || (s[15:12] == abt_pkg::SW1_APP_HI);
    end
endmodule

//--- verilog/abt_card_transport.sv
`timescale 1ns/1ps
// What this block does
// - Response data only with 61,62,63,9X status
// - Long responses split over chained blocks
// - All four data cases supported
// - Exactly one response per command
// - 91XX replaces 9000 when proactive pending
// - Fetch answered with command then 90 00
// - Busy toolkit answers envelope with 9300
// - Proactive sequence independent of transport protocol
module abt_card_transport #(
    parameter int BLK_MAX = abt_pkg::BLK_MAX
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] rx_byte,
    input wire logic rx_valid,
    input wire logic rx_blk_end,
    input wire logic rx_chained,
    output logic [7:0] tx_byte,
    output logic tx_valid,
    output logic tx_blk_end,
    output logic tx_chained,
    input wire logic tx_ready,
    output logic [7:0] cmd_ins,
    output logic [7:0] cmd_byte,
    output logic cmd_byte_valid,
    output logic cmd_start,
    output logic cmd_done,
    input wire logic [7:0] rsp_byte,
    input wire logic rsp_valid,
    output logic rsp_ready,
    input wire logic rsp_last,
    input wire logic rsp_none,
    input wire logic [15:0] rsp_sw,
    input wire logic rsp_sw_valid,
    input wire logic tk_busy,
    input wire logic pro_load,
    input wire logic [7:0] pro_byte,
    input wire logic [7:0] pro_len,
    output logic pro_pending
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        abt_pkg::abt_state_e st;
        logic [2:0] hdr_cnt;
        logic [7:0] ins;
        logic [7:0] blk_cnt;
        logic [15:0] sw;
        logic fetch;
        logic pend;
        logic [7:0] plen;
        logic [7:0] pidx;
        logic [7:0] tx_byte;
        logic tx_valid;
        logic tx_blk_end;
        logic tx_chained;
        logic [7:0] cmd_byte;
        logic cmd_byte_valid;
        logic cmd_start;
        logic cmd_done;
        logic rsp_ready;
    } abt_s;

    abt_s r;
    abt_s next_r;

    logic [15:0] sw_final;
    logic data_ok;

    abt_sw_filter u_filter (
        .sw(r.sw),
        .pending(r.pend),
        .tk_busy(tk_busy),
        .is_envelope(r.ins == abt_pkg::INS_ENVELOPE),
        .sw_out(sw_final),
        .data_ok(data_ok)
    );

    // Proactive command byte store
    logic [7:0] pro_mem [0:255];
    always_ff @(posedge clk) begin
        if (pro_load) begin
            pro_mem[pro_len] <= pro_byte;
        end
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        logic tx_go;
        logic byte_out;
        logic [7:0] b;
        tx_go = 1'b0;
        byte_out = 1'b0;
        b = 8'h00;
        next_r = r;
        next_r.cmd_byte_valid = 1'b0;
        next_r.cmd_start = 1'b0;
        next_r.cmd_done = 1'b0;
        next_r.rsp_ready = 1'b0;
        tx_go = r.tx_valid && tx_ready;
        if (tx_go) begin
            next_r.tx_valid = 1'b0;
            next_r.tx_blk_end = 1'b0;
            next_r.tx_chained = 1'b0;
        end
        case (r.st)
            abt_pkg::ABT_IDLE: begin
                if (rx_valid) begin
                    next_r.hdr_cnt = 3'd1;
                    next_r.st = abt_pkg::ABT_CMD;
                    next_r.cmd_start = 1'b1;
                    next_r.cmd_byte = rx_byte;
                    next_r.cmd_byte_valid = 1'b1;
                    next_r.fetch = 1'b0;
                end
            end
            abt_pkg::ABT_CMD: begin
                // Command bytes accepted across chained blocks
                if (rx_valid) begin
                    if (r.hdr_cnt == 3'(abt_pkg::HDR_INS)) begin
                        next_r.ins = rx_byte;
                        next_r.fetch = (rx_byte == abt_pkg::INS_FETCH);
                    end
                    if (r.hdr_cnt < 3'(abt_pkg::HDR_BYTES)) begin
                        next_r.hdr_cnt = r.hdr_cnt + 3'd1;
                    end
                    next_r.cmd_byte = rx_byte;
                    next_r.cmd_byte_valid = 1'b1;
                end
                if (rx_valid && rx_blk_end && !rx_chained) begin
                    next_r.cmd_done = 1'b1;
                    next_r.st = abt_pkg::ABT_EXEC;
                    next_r.blk_cnt = 8'h00;
                    next_r.pidx = 8'h00;
                end
            end
            abt_pkg::ABT_EXEC: begin
                if (r.fetch) begin
                    // Proactive command served then 90 00
                    next_r.sw = {abt_pkg::SW1_OK, abt_pkg::SW2_OK};
                    next_r.pend = 1'b0;
                    next_r.st = (r.plen != 8'h00) ? abt_pkg::ABT_DATA : abt_pkg::ABT_SW1;
                end else if (rsp_sw_valid) begin
                    next_r.sw = rsp_sw;
                    next_r.st = rsp_none ? abt_pkg::ABT_SW1 : abt_pkg::ABT_DATA;
                end
            end
            abt_pkg::ABT_DATA: begin
                if (!r.tx_valid || tx_go) begin
                    if (r.fetch) begin
                        b = pro_mem[r.pidx];
                        byte_out = 1'b1;
                        next_r.pidx = r.pidx + 8'h01;
                        if (r.pidx + 8'h01 == r.plen) begin
                            next_r.st = abt_pkg::ABT_SW1;
                        end
                    end else if (!data_ok) begin
                        next_r.st = abt_pkg::ABT_SW1;
                    end else if (rsp_valid && !r.rsp_ready) begin
                        // Skip the cycle in which the producer steps past a taken byte
                        b = rsp_byte;
                        byte_out = 1'b1;
                        next_r.rsp_ready = 1'b1;
                        if (rsp_last) begin
                            next_r.st = abt_pkg::ABT_SW1;
                        end
                    end
                end
                if (byte_out) begin
                    next_r.tx_byte = b;
                    next_r.tx_valid = 1'b1;
                    // Block full: close it and chain the rest
                    if (r.blk_cnt == 8'(BLK_MAX - 1)) begin
                        next_r.tx_blk_end = 1'b1;
                        next_r.tx_chained = 1'b1;
                        next_r.blk_cnt = 8'h00;
                    end else begin
                        next_r.blk_cnt = r.blk_cnt + 8'h01;
                    end
                end
            end
            abt_pkg::ABT_SW1: begin
                if (!r.tx_valid || tx_go) begin
                    next_r.tx_byte = r.fetch ? r.sw[15:8] : sw_final[15:8];
                    next_r.tx_valid = 1'b1;
                    next_r.st = abt_pkg::ABT_SW2;
                end
            end
            abt_pkg::ABT_SW2: begin
                if (!r.tx_valid || tx_go) begin
                    // One response closes every command
                    next_r.tx_byte = r.fetch ? r.sw[7:0] :
                        ((sw_final[15:8] == abt_pkg::SW1_PENDING) ? r.plen : sw_final[7:0]);
                    next_r.tx_valid = 1'b1;
                    next_r.tx_blk_end = 1'b1;
                    next_r.tx_chained = 1'b0;
                    next_r.st = abt_pkg::ABT_IDLE;
                end
            end
            default: begin
                next_r.st = abt_pkg::ABT_IDLE;
            end
        endcase
        // A load wins over the clear made by a fetch in the same cycle
        if (pro_load) begin
            next_r.plen = pro_len + 8'h01;
            next_r.pend = 1'b1;
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign tx_byte = r.tx_byte;
    assign tx_valid = r.tx_valid;
    assign tx_blk_end = r.tx_blk_end;
    assign tx_chained = r.tx_chained;
    assign cmd_ins = r.ins;
    assign cmd_byte = r.cmd_byte;
    assign cmd_byte_valid = r.cmd_byte_valid;
    assign cmd_start = r.cmd_start;
    assign cmd_done = r.cmd_done;
    assign rsp_ready = r.rsp_ready;
    assign pro_pending = r.pend;

endmodule

//--- tb/abt_monitor.sv
`timescale 1ns/1ps
module abt_monitor (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] rx_byte,
    input wire logic rx_valid,
    input wire logic rx_blk_end,
    input wire logic rx_chained,
    input wire logic [7:0] tx_byte,
    input wire logic tx_valid,
    input wire logic tx_blk_end,
    input wire logic tx_chained,
    input wire logic tx_ready,
    input wire logic [7:0] cmd_ins,
    input wire logic [7:0] cmd_byte,
    input wire logic cmd_byte_valid,
    input wire logic cmd_start,
    input wire logic cmd_done,
    input wire logic rsp_valid,
    input wire logic rsp_ready,
    input wire logic pro_load,
    input wire logic pro_pending
);
    // ----
    // Port checks
    // ----
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_wait;
        tx_valid && !tx_ready;
    endsequence
    sequence s_held;
        tx_valid && $stable({tx_byte, tx_blk_end, tx_chained});
    endsequence
    a_tx_held: assert property (s_wait |=> s_held) else $error("tx byte left early");
    a_chain_end: assert property (tx_valid && tx_chained |-> tx_blk_end) else $error("chain flag off end");
    a_cmd_echo: assert property (cmd_byte_valid |-> $past(rx_valid) && cmd_byte == $past(rx_byte))
        else $error("command byte altered");
    a_start_first: assert property (cmd_start |-> cmd_byte_valid) else $error("start without byte");
    a_done_cause: assert property (cmd_done |-> $past(rx_valid && rx_blk_end && !rx_chained))
        else $error("done without last byte");
    a_ready_data: assert property (rsp_ready |-> rsp_valid) else $error("ready without data");
    a_pend_set: assert property (pro_load |=> pro_pending) else $error("pending not set");
    a_pend_clear: assert property ($fell(pro_pending) |-> cmd_ins == abt_pkg::INS_FETCH)
        else $error("pending cleared outside fetch");
    a_quiet_start: assert property ($rose(rst_n) |-> !tx_valid && !pro_pending)
        else $error("busy out of reset");
endmodule
bind abt_card_transport abt_monitor u_mon (.clk, .rst_n, .rx_byte, .rx_valid, .rx_blk_end, .rx_chained,
    .tx_byte, .tx_valid, .tx_blk_end, .tx_chained, .tx_ready, .cmd_ins, .cmd_byte, .cmd_byte_valid,
    .cmd_start, .cmd_done, .rsp_valid, .rsp_ready, .pro_load, .pro_pending);

//--- tb/abt_proc_model.sv
`timescale 1ns/1ps
module abt_proc_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cmd_done,
    input wire logic [7:0] cmd_ins,
    input wire logic rsp_ready,
    input wire logic [7:0] cfg_len,
    input wire logic [15:0] cfg_sw,
    input wire logic slow,
    output logic [7:0] rsp_byte,
    output logic rsp_valid,
    output logic rsp_last,
    output logic rsp_none,
    output logic [15:0] rsp_sw,
    output logic rsp_sw_valid
);
    // ----
    // Command processor
    // ----
    logic [7:0] idx;
    logic [3:0] dly;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_valid <= 1'b0;
            rsp_sw_valid <= 1'b0;
            dly <= 4'h0;
            idx <= 8'h00;
        end else begin
            dly <= {dly[2:0], cmd_done && cmd_ins !== abt_pkg::INS_FETCH};
            rsp_sw_valid <= slow ? dly[3] : dly[0];
            if (cmd_done) begin
                rsp_valid <= 1'b0;
            end else if (rsp_sw_valid && cfg_len != 8'h00) begin
                rsp_valid <= 1'b1;
                idx <= 8'h00;
            end else if (rsp_valid && rsp_ready) begin
                rsp_valid <= idx + 8'h01 < cfg_len;
                idx <= idx + 8'h01;
            end
        end
    end
    assign rsp_sw = rsp_sw_valid ? cfg_sw : ~cfg_sw;
    assign rsp_none = cfg_len == 8'h00;
    assign rsp_byte = rsp_valid ? 8'hA0 + idx : 8'h5A ^ idx;
    assign rsp_last = rsp_valid && idx + 8'h01 == cfg_len;
endmodule

//--- tb/apdu_block_transport_t1_tb_top.sv
`timescale 1ns/1ps
module apdu_block_transport_t1_tb_top;
    logic clk = 0, rst_n = 0, rx_valid = 0, rx_blk_end = 0, rx_chained = 0, tx_ready = 1;
    logic tk_busy = 0, pro_load = 0, slow = 0, stall = 0;
    logic [7:0] rx_byte = 0, pro_byte = 0, pro_len = 0, len = 0, tx_byte, cmd_ins, cmd_byte, rsp_byte;
    logic [15:0] sw = 0, rsp_sw;
    logic tx_valid, tx_blk_end, tx_chained, cmd_byte_valid, cmd_start, cmd_done;
    logic rsp_valid, rsp_ready, rsp_last, rsp_none, rsp_sw_valid, pro_pending;
    logic [9:0] q[$];
    logic [15:0] tbl[5] = '{16'h6110, 16'h6283, 16'h63C1, 16'h9F10, 16'h9000};
    int fails = 0, total_checks = 0;
    localparam int TB_BLK = 4;
    // ----
    // Harness
    // ----
    always #2 clk = ~clk;
    always @(posedge clk) begin
        tx_ready <= stall ? ~tx_ready : 1'b1;
        if (tx_valid && tx_ready)
            q.push_back({tx_chained, tx_blk_end, tx_byte});
    end
    abt_card_transport #(.BLK_MAX(TB_BLK)) uut (.clk, .rst_n, .rx_byte, .rx_valid, .rx_blk_end, .rx_chained,
        .tx_byte, .tx_valid, .tx_blk_end, .tx_chained, .tx_ready, .cmd_ins, .cmd_byte, .cmd_byte_valid,
        .cmd_start, .cmd_done, .rsp_byte, .rsp_valid, .rsp_ready, .rsp_last, .rsp_none, .rsp_sw,
        .rsp_sw_valid, .tk_busy, .pro_load, .pro_byte, .pro_len, .pro_pending);
    abt_proc_model pm (.clk, .rst_n, .cmd_done, .cmd_ins, .rsp_ready, .cfg_len(len), .cfg_sw(sw), .slow,
        .rsp_byte, .rsp_valid, .rsp_last, .rsp_none, .rsp_sw, .rsp_sw_valid);
    task chk(input logic [9:0] seen, input logic [9:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task send(input logic [7:0] ins, input int n, input int split, input logic [7:0] last);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            rx_valid <= 1'b1;
            rx_byte <= i == 1 ? ins : i == n - 1 ? last : 8'h10 + 8'(i);
            rx_blk_end <= i == split - 1 || i == n - 1;
            rx_chained <= i == split - 1 && i != n - 1;
        end
        @(posedge clk);
        rx_valid <= 1'b0;
        chk(10'(cmd_ins), 10'(ins));
    endtask
    task expect_rsp(input int n, input logic [15:0] esw);
        int k;
        logic [9:0] e;
        k = 0;
        e = 10'h000;
        while ((q.size() == 0 || q[$][9:8] !== 2'b01) && k < 400) begin
            @(posedge clk);
            k++;
        end
        if (k >= 400)
            fails++;
        chk(10'(q.size()), 10'(n + 2));
        for (int i = 0; i < n + 2 && i < q.size(); i++) begin
            if (i >= n)
                e = {1'b0, i == n + 1, i == n ? esw[15:8] : esw[7:0]};
            else
                e = {i % TB_BLK == TB_BLK - 1, i % TB_BLK == TB_BLK - 1, 8'hA0 + 8'(i)};
            chk(q[i], e);
        end
        q.delete();
        repeat (2) @(posedge clk);
    endtask
    // ----
    // Scenarios
    // ----
    task t_plain;
        len <= 8'h03;
        sw <= 16'h6A82;
        send(8'hB0, 4, 4, 8'h13);
        expect_rsp(0, 16'h6A82);
        $display("t_plain done");
    endtask
    task t_classes;
        len <= 8'h02;
        for (int i = 0; i < 5; i++) begin
            sw <= tbl[i];
            send(8'hB2, 7, 7, 8'h16);
            expect_rsp(2, tbl[i]);
        end
        $display("t_classes done");
    endtask
    task t_chain;
        stall <= 1'b1;
        slow <= 1'b1;
        len <= 8'h06;
        sw <= 16'h9000;
        send(8'hD6, 9, 5, 8'h18);
        expect_rsp(6, 16'h9000);
        stall <= 1'b0;
        slow <= 1'b0;
        $display("t_chain done");
    endtask
    task t_proactive;
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            pro_load <= 1'b1;
            pro_len <= 8'(i);
            pro_byte <= 8'hA0 + 8'(i);
        end
        @(posedge clk);
        pro_load <= 1'b0;
        @(posedge clk);
        chk(pro_pending, 1);
        len <= 8'h00;
        send(8'hB0, 5, 5, 8'h14);
        expect_rsp(0, 16'h9103);
        send(abt_pkg::INS_FETCH, 5, 5, 8'h03);
        expect_rsp(3, 16'h9000);
        chk(pro_pending, 0);
        send(abt_pkg::INS_TERM_RSP, 6, 6, 8'h15);
        expect_rsp(0, 16'h9000);
        $display("t_proactive done");
    endtask
    task t_envelope;
        tk_busy <= 1'b1;
        send(abt_pkg::INS_ENVELOPE, 8, 8, 8'h00);
        expect_rsp(0, 16'h9300);
        tk_busy <= 1'b0;
        len <= 8'h02;
        sw <= 16'h6283;
        send(abt_pkg::INS_ENVELOPE, 8, 8, 8'h00);
        expect_rsp(2, 16'h6283);
        sw <= 16'h9000;
        send(abt_pkg::INS_ENVELOPE, 8, 8, 8'h00);
        expect_rsp(2, 16'h9000);
        $display("t_envelope done");
    endtask
    task stop_test;
        $display("checks=%0d fails=%0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_plain();
        t_classes();
        t_chain();
        t_proactive();
        t_envelope();
        stop_test();
    end
    initial begin
        #100000;
        fails++;
        stop_test();
    end
endmodule
